// *** verilog/adc_seq_pkg.sv ***
`default_nettype none
package adc_seq_pkg;
	// Register byte offsets on the APB side.
	localparam logic [7:0] OFS_MODE     = 8'h00;
	localparam logic [7:0] OFS_RESULT   = 8'h04;
	localparam logic [7:0] OFS_BITSET   = 8'h08;
	localparam logic [7:0] OFS_BITCLR   = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
	localparam logic [7:0] OFS_CLK_CFG  = 8'h1c;

	// Mode register layout and reset values.
	localparam int         MODE_DONE_BIT  = 2;
	localparam int         MODE_START_BIT = 3;
	localparam int         MODE_CH_LSB    = 4;
	localparam int         MODE_CH_MSB    = 6;
	localparam logic [7:0] MODE_WMASK     = 8'h7f;
	localparam logic [7:0] MODE_BITMASK   = 8'h0c;
	localparam logic [7:0] MODE_RESET     = 8'h04;
	localparam logic [7:0] RESULT_RESET   = 8'h7f;

	// Clock configuration layout.
	localparam int         CLK_SUB_BIT  = 0;
	localparam int         CLK_DIV0_BIT = 1;
	localparam int         CLK_DIV1_BIT = 2;
	localparam int         CLK_STOP_BIT = 3;
	localparam int         CLK_BUSY_BIT = 8;
	localparam logic [3:0] CLK_RESET    = 4'h0;

	// Interrupt status layout.
	localparam int         IRQ_DONE_BIT    = 0;
	localparam int         IRQ_RESTART_BIT = 1;
	localparam logic [1:0] IRQ_RESET       = 2'h0;

	// Timing, in main oscillator periods and in pclk cycles.
	localparam int PCLK_KHZ          = 20000;
	localparam int FX_KHZ            = 20000;
	localparam int CONV_FX_PERIODS   = 168;
	localparam int START_FX_PERIODS  = 16;
	localparam int CONV_CYC  = (CONV_FX_PERIODS * PCLK_KHZ) / FX_KHZ;
	localparam int START_MAX_CYC =
		(START_FX_PERIODS * PCLK_KHZ) / FX_KHZ;
	localparam int RES_BITS  = 8;
	localparam int STEP_CYC  = CONV_CYC / RES_BITS;
	localparam logic [4:0] STEP_LAST  = 5'(STEP_CYC - 1);
	localparam logic [4:0] START_LAST = 5'h03;
	localparam logic [7:0] TRIAL_MSB  = 8'h80;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_DELAY = 2'h1,
		ST_CONV  = 2'h3
	} seq_state_t;
endpackage
`default_nettype wire

// *** verilog/sar_adc_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer (
	// APB slave.
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	// Power state from the clock controller.
	input  wire logic       stop_mode,
	input  wire logic       halt_mode,
	// Analog front end.
	input  wire logic       compare_in,
	output logic [2:0]      channel_select,
	output logic [7:0]      dac_code,
	output logic            sample_hold,
	// Interrupt.
	output logic            irq
);
	import adc_seq_pkg::*;

	seq_state_t  state_reg, state_next;
	logic [7:0]  mode_reg, mode_next;
	logic [7:0]  result_reg, result_next;
	logic [7:0]  trial_reg, trial_next;
	logic [4:0]  cnt_reg, cnt_next;
	logic [2:0]  bit_reg, bit_next;
	logic [3:0]  clk_reg, clk_next;
	logic [1:0]  stat_reg, stat_next;
	logic [1:0]  en_reg, en_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        cmp_s1, cmp_s2, cmp_s3, cmp_lvl;
	logic        cmp_lvl_next;
	logic        wr, setup, mapped, run_ok;
	logic        done_ev, restart_ev;
	logic [1:0]  irq_ev;
	logic [7:0]  trial_dec;

	assign wr     = psel && penable && pwrite;
	assign setup  = psel && !penable;
	assign pready = 1'b1;
	assign mapped = (paddr == OFS_MODE) || (paddr == OFS_RESULT) ||
		(paddr == OFS_BITSET) || (paddr == OFS_BITCLR) ||
		(paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_CLR) ||
		(paddr == OFS_IRQ_EN) || (paddr == OFS_CLK_CFG);
	assign pslverr = psel && penable && !mapped;
	assign prdata  = rdata_reg;

	// The converter runs from the main clock only, so any of these
	// freezes the sequence where it stands until the clock returns.
	assign run_ok = !clk_reg[CLK_STOP_BIT] && !stop_mode &&
		!(halt_mode && clk_reg[CLK_SUB_BIT]);

	assign channel_select = mode_reg[MODE_CH_MSB:MODE_CH_LSB];
	assign dac_code       = trial_reg;
	assign sample_hold    = (state_reg == ST_CONV);
	assign irq            = |(stat_reg & en_reg);

	// Comparator result is asynchronous to pclk; a new level counts
	// only once the second and third stages agree.
	always_comb begin
		cmp_lvl_next = cmp_lvl;
		if (cmp_s2 == cmp_s3) begin
			cmp_lvl_next = cmp_s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_s1  <= 1'b0;
			cmp_s2  <= 1'b0;
			cmp_s3  <= 1'b0;
			cmp_lvl <= 1'b0;
		end else begin
			cmp_s1  <= compare_in;
			cmp_s2  <= cmp_s1;
			cmp_s3  <= cmp_s2;
			cmp_lvl <= cmp_lvl_next;
		end
	end

	// Trial word after the current bit has been judged.
	always_comb begin
		trial_dec = trial_reg;
		if (!cmp_lvl) begin
			trial_dec[bit_reg] = 1'b0;
		end
	end

	always_comb begin
		state_next  = state_reg;
		mode_next   = mode_reg;
		result_next = result_reg;
		trial_next  = trial_reg;
		cnt_next    = cnt_reg;
		bit_next    = bit_reg;
		clk_next    = clk_reg;
		en_next     = en_reg;
		rdata_next  = rdata_reg;
		done_ev     = 1'b0;
		restart_ev  = 1'b0;

		// Sequencer; hardware clears come before software writes so
		// that a start written in the same cycle is not lost.
		if (run_ok) begin
			if (mode_reg[MODE_START_BIT]) begin
				restart_ev = (state_reg != ST_IDLE);
				state_next = ST_DELAY;
				cnt_next   = 5'h00;
				mode_next[MODE_START_BIT] = 1'b0;
			end else begin
				case (state_reg)
				ST_DELAY: begin
					if (cnt_reg == START_LAST) begin
						state_next = ST_CONV;
						mode_next[MODE_DONE_BIT] = 1'b0;
						trial_next = TRIAL_MSB;
						bit_next   = 3'h7;
						cnt_next   = 5'h00;
					end else begin
						cnt_next = cnt_reg + 5'h01;
					end
				end
				ST_CONV: begin
					if (cnt_reg == STEP_LAST) begin
						cnt_next = 5'h00;
						if (bit_reg == 3'h0) begin
							result_next = trial_dec;
							trial_next  = trial_dec;
							done_ev     = 1'b1;
							state_next  = ST_IDLE;
						end else begin
							trial_next = trial_dec;
							trial_next[bit_reg - 3'h1] = 1'b1;
							bit_next = bit_reg - 3'h1;
						end
					end else begin
						cnt_next = cnt_reg + 5'h01;
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
				endcase
			end
		end

		// Register writes; the result register has no write path.
		if (wr) begin
			if (paddr == OFS_MODE) begin
				mode_next = pwdata[7:0] & MODE_WMASK;
			end else if (paddr == OFS_BITSET) begin
				mode_next = mode_next | (pwdata[7:0] & MODE_BITMASK);
			end else if (paddr == OFS_BITCLR) begin
				mode_next = mode_next & ~(pwdata[7:0] & MODE_BITMASK);
			end else if (paddr == OFS_IRQ_EN) begin
				en_next = pwdata[1:0];
			end else if (paddr == OFS_CLK_CFG) begin
				clk_next = pwdata[3:0];
			end
		end

		// Completion flag set wins over a software clear.
		if (done_ev) begin
			mode_next[MODE_DONE_BIT] = 1'b1;
		end

		if (setup) begin
			rdata_next = 32'h0000_0000;
			if (paddr == OFS_MODE) begin
				rdata_next[7:0] = mode_reg;
			end else if (paddr == OFS_RESULT) begin
				rdata_next[7:0] = result_reg;
			end else if (paddr == OFS_IRQ_STAT) begin
				rdata_next[1:0] = stat_reg;
			end else if (paddr == OFS_IRQ_EN) begin
				rdata_next[1:0] = en_reg;
			end else if (paddr == OFS_CLK_CFG) begin
				rdata_next[3:0] = clk_reg;
				rdata_next[CLK_BUSY_BIT] = (state_reg != ST_IDLE);
			end
		end
	end

	// Sticky interrupt status; a new event beats a clear.
	assign irq_ev = {restart_ev, done_ev};
	always_comb begin
		stat_next = stat_reg;
		if (wr && (paddr == OFS_IRQ_CLR)) begin
			stat_next = stat_reg & ~pwdata[1:0];
		end
		stat_next = stat_next | irq_ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= ST_IDLE;
			mode_reg   <= MODE_RESET;
			result_reg <= RESULT_RESET;
			trial_reg  <= 8'h00;
			cnt_reg    <= 5'h00;
			bit_reg    <= 3'h0;
			clk_reg    <= CLK_RESET;
			stat_reg   <= IRQ_RESET;
			en_reg     <= IRQ_RESET;
			rdata_reg  <= 32'h0000_0000;
		end else begin
			state_reg  <= state_next;
			mode_reg   <= mode_next;
			result_reg <= result_next;
			trial_reg  <= trial_next;
			cnt_reg    <= cnt_next;
			bit_reg    <= bit_next;
			clk_reg    <= clk_next;
			stat_reg   <= stat_next;
			en_reg     <= en_next;
			rdata_reg  <= rdata_next;
		end
	end

	// Helper: running cycles spent converting, for the length check.
	logic [7:0] age_reg, age_next;
	always_comb begin
		age_next = age_reg;
		if (state_reg != ST_CONV) begin
			age_next = 8'h00;
		end else if (run_ok) begin
			age_next = age_reg + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_reg <= 8'h00;
		end else begin
			age_reg <= age_next;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_take;
		mode_reg[MODE_START_BIT] && run_ok && !wr;
	endsequence
	sequence s_begin;
		state_reg == ST_DELAY && state_next == ST_CONV;
	endsequence
	sequence s_finish;
		state_reg == ST_CONV && state_next == ST_IDLE;
	endsequence

	a_start_self_clear: assert property (
		s_take |=> !mode_reg[MODE_START_BIT] && state_reg == ST_DELAY)
		else $error("start request not taken and cleared");
	a_begin_clears_done: assert property (
		s_begin and !wr |=> !mode_reg[MODE_DONE_BIT] &&
		trial_reg == TRIAL_MSB && bit_reg == 3'h7)
		else $error("conversion began with bad flag or trial");
	a_delay_bound: assert property (
		state_reg == ST_DELAY |-> cnt_reg < 5'(START_MAX_CYC))
		else $error("start delay beyond limit");
	a_conv_length: assert property (
		s_finish |-> age_reg == 8'(CONV_CYC - 1))
		else $error("conversion length wrong");
	a_finish_loads: assert property (
		s_finish |=> mode_reg[MODE_DONE_BIT] &&
		result_reg == $past(trial_dec) && stat_reg[IRQ_DONE_BIT])
		else $error("finish did not load result and flag");
	a_result_readonly: assert property (
		wr && paddr == OFS_RESULT && state_reg == ST_IDLE
		|=> $stable(result_reg))
		else $error("result register changed by write");
	a_halt_freezes: assert property (
		state_reg == ST_CONV && !run_ok |=> $stable(trial_reg) &&
		$stable(cnt_reg) && state_reg == ST_CONV)
		else $error("conversion advanced without main clock");
	a_hold_conv: assert property (
		s_begin |=> sample_hold [*8])
		else $error("sample held too briefly");
	a_channel_write: assert property (
		wr && paddr == OFS_MODE |=>
		channel_select == $past(pwdata[6:4]))
		else $error("channel select not taken from write");
	a_restart_conv: assert property (
		state_reg == ST_CONV ##0 s_take |=> state_reg == ST_DELAY &&
		stat_reg[IRQ_RESTART_BIT])
		else $error("restart did not abandon conversion");
	a_bitset_only: assert property (
		wr && paddr == OFS_BITSET |=>
		mode_reg[7:4] == $past(mode_reg[7:4]) &&
		mode_reg[1:0] == $past(mode_reg[1:0]))
		else $error("single-bit set disturbed other bits");
endmodule
`default_nettype wire

// *** test/analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module analog_model (
	// Converter side.
	input  wire logic       pclk,
	input  wire logic [2:0] channel_select,
	input  wire logic [7:0] dac_code,
	input  wire logic       sample_hold,
	output logic            compare_in
);
	logic [7:0] vin [8];
	logic [7:0] held;
	// The end channels sit at the rails to reach both ends of the code.
	// Nothing here reads the shared digital port while converting.
	initial vin = '{8'h00, 8'h2e, 8'h4b, 8'h68, 8'h85, 8'ha2, 8'hbf, 8'hff};
	// Tracks the input while open, so a late input change must not leak in.
	always_ff @(posedge pclk) begin
		if (!sample_hold) held <= vin[channel_select];
	end
	assign compare_in = (held >= dac_code);
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import adc_seq_pkg::*;
	localparam int T_DONE = 5 + CONV_FX_PERIODS;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        stop_mode = 1'b0;
	logic        halt_mode = 1'b0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, compare_in, sample_hold, irq, e;
	logic [2:0]  channel_select;
	logic [7:0]  dac_code;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          n, t0;

	always #25 pclk = ~pclk;

	sar_adc_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stop_mode(stop_mode), .halt_mode(halt_mode),
		.compare_in(compare_in), .channel_select(channel_select),
		.dac_code(dac_code), .sample_hold(sample_hold), .irq(irq));
	analog_model pm (.pclk(pclk), .channel_select(channel_select),
		.dac_code(dac_code), .sample_hold(sample_hold),
		.compare_in(compare_in));

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Enters on a fresh edge, so a release never meets a new setup.
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] rq, output logic er);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			miscompares++;
			tally_and_finish();
		end
		rq = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, q, e);
		check(q, exp);
	endtask

	// Counts edges until the done interrupt, freezing the clock for flen edges from edge frz.
	task automatic wait_done(input int frz, input int flen, input logic hlt,
			output int c, output int h);
		c = 0;
		h = 0;
		do begin
			@(posedge pclk);
			if (hlt)
				halt_mode <= (c >= frz && c < frz + flen);
			else
				stop_mode <= (c >= frz && c < frz + flen);
			#1;
			c++;
			if (sample_hold === 1'b1 && h == 0) begin
				h = c;
				check({24'h0, dac_code}, {24'h0, TRIAL_MSB});
			end
			if (c == 40) pm.vin[channel_select] = ~pm.vin[channel_select];
		end while (irq !== 1'b1 && c < 2000);
		pm.vin[channel_select] = ~pm.vin[channel_select];
		if (c >= 2000) begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	task automatic conv(input logic [2:0] ch, input int flen,
			input logic hlt);
		int tol;
		logic [7:0] v;
		tol = (flen > 0) ? 2 : 0;
		v = pm.vin[ch];
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_MODE, {25'h0, ch, 4'h8});
		wait_done(30, flen, hlt, n, t0);
		check({29'h0, channel_select}, {29'h0, ch});
		check(32'(t0 >= 1 && t0 <= 16), 32'h1);
		check(32'(n >= T_DONE + flen - tol), 32'h1);
		check(32'(n <= T_DONE + flen + tol), 32'h1);
		rd_chk(OFS_RESULT, {24'h0, v});
		rd_chk(OFS_MODE, {25'h0, ch, 4'h4});
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFS_MODE, 32'h4);
		rd_chk(OFS_RESULT, 32'h7f);
		wr(OFS_RESULT, 32'h55);
		rd_chk(OFS_RESULT, 32'h7f);
		apb(1'b0, 8'h20, 32'h0, q, e);
		check({31'h0, e}, 32'h1);
		wr(OFS_IRQ_EN, 32'h1);
		for (int c = 0; c < 8; c++) conv(3'(c), 0, 1'b0);
		conv(3'h5, 100, 1'b0);
		wr(OFS_CLK_CFG, 32'h1);
		conv(3'h2, 80, 1'b1);
		wr(OFS_CLK_CFG, 32'h0);
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_MODE, 32'h38);
		repeat (60) @(posedge pclk);
		rd_chk(OFS_MODE, 32'h30);
		wr(OFS_BITSET, 32'h8);
		wait_done(5000, 0, 1'b0, n, t0);
		check(32'(n == T_DONE), 32'h1);
		rd_chk(OFS_IRQ_STAT, 32'h3);
		wr(OFS_BITCLR, 32'h4);
		rd_chk(OFS_MODE, 32'h30);
		wr(OFS_BITSET, 32'h4);
		rd_chk(OFS_MODE, 32'h34);
		wr(OFS_IRQ_EN, 32'h0);
		#1;
		check({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_EN, 32'h1);
		#1;
		check({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_CLR, 32'h1);
		#1;
		check({31'h0, irq}, 32'h0);
		rd_chk(OFS_IRQ_EN, 32'h1);
		wr(OFS_CLK_CFG, 32'he);
		wr(OFS_MODE, 32'h18);
		repeat (20) @(posedge pclk);
		rd_chk(OFS_MODE, 32'h18);
		rd_chk(OFS_CLK_CFG, 32'he);
		wr(OFS_CLK_CFG, 32'h0);
		rd_chk(OFS_CLK_CFG, 32'h100);
		wait_done(5000, 0, 1'b0, n, t0);
		rd_chk(OFS_RESULT, {24'h0, pm.vin[1]});
		rd_chk(OFS_MODE, 32'h14);
		tally_and_finish();
	end
endmodule
`default_nettype wire
